// *** shared/tcs_defines.vh ***
// What this block does
// - bit 7: timer 3 high byte system clock
// - bit 6: timer 3 low/whole system clock
// - bit 5: timer 2 high byte system clock
// - bit 4: timer 2 low/whole system clock
// - bit 3: timer 1 system clock or prescaler
// - bit 2: timer 0 system clock or prescaler
// - prescale field: /12, /4, /48, ext/8
// - timer 1 overflow flag, auto-cleared on vector
// - timer 0 overflow flag, auto-cleared on vector
// - timer 1 runs while its run bit set
// - timer 0 runs while its run bit set
// - ext irq 1 flag; edge mode vector clears
// - ext irq 0 flag; edge mode vector clears
// - ext irq 1 type: 0 level, 1 edge
// - ext irq 0 type: 0 level
// - timer control at 0x88, bit addressable
// - clock select at 0x8E page 0, reset zero
// - timer 3 sources: sys, /12, ext/8, slow
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH

// register map
`define TCS_PAGE           8'h00
`define TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_ADDR      8'h88
`define TCS_CKSEL_ADDR     8'h8E
`define TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_BITBASE   5'h11
`define TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_RESET     8'h00
`define TCS_CKSEL_RESET    8'h00
`define TCS_UNMAPPED_READ  8'h00

// clock select fields
`define TCS_CK_T3H   7
`define TCS_CK_T3L   6
`define TCS_CK_T2H   5
`define TCS_CK_T2L   4
`define TCS_CK_T1    3
`define TCS_CK_T0    2
`define TCS_CK_PS_HI 1
`define TCS_CK_PS_LO 0

// timer control fields
`define TCS_TC_TF1 7
`define TCS_TC_TR1 6
`define TCS_TC_TF0 5
`define TCS_TC_TR0 4
`define TCS_TC_IE1 3
`define TCS_TC_IT1 2
`define TCS_TC_IE0 1
`define TCS_TC_IT0 0

// divide counts
`define TCS_DIV12  6'd12
`define TCS_DIV4   6'd4
`define TCS_DIV48  6'd48
`define TCS_DIV8   3'd7

`endif

// *** core/tcs_prescaler.v ***
`timescale 1ns/1ps
`include "tcs_defines.vh"

module tcs_prescaler
(
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       clkEn,
  // raw sources
  input  wire       extOscIn,
  input  wire       slowOscIn,
  input  wire       cmp0In,
  // one-cycle ticks
  output reg        div12Tick,
  output reg        div4Tick,
  output reg        div48Tick,
  output reg        extDiv8Tick,
  output reg        slowTick,
  output reg        slowDiv8Tick,
  output reg        cmpTick
);

  reg  [5:0] sysCnt_reg;
  reg  [2:0] extCnt_reg;
  reg  [2:0] slowCnt_reg;
  reg        extPrev_reg;
  reg        slowPrev_reg;
  reg        cmpPrev_reg;
  wire       extRise  = extOscIn & ~extPrev_reg;
  wire       slowRise = slowOscIn & ~slowPrev_reg;

  // true when count+1 is a multiple of n
  function hits;
    input [5:0] cnt;
    input [5:0] n;
    begin
      hits = (((cnt + 6'd1) % n) == 6'd0);
    end
  endfunction

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sysCnt_reg   <= 6'h00;
      extCnt_reg   <= 3'h0;
      slowCnt_reg  <= 3'h0;
      extPrev_reg  <= 1'b0;
      slowPrev_reg <= 1'b0;
      cmpPrev_reg  <= 1'b0;
      div12Tick    <= 1'b0;
      div4Tick     <= 1'b0;
      div48Tick    <= 1'b0;
      extDiv8Tick  <= 1'b0;
      slowTick     <= 1'b0;
      slowDiv8Tick <= 1'b0;
      cmpTick      <= 1'b0;
    end
    else if (clkEn)
    begin
      // one free counter of period 48 serves all system dividers
      sysCnt_reg   <= (sysCnt_reg == `TCS_DIV48 - 6'd1) ? 6'h00
                      : sysCnt_reg + 6'd1;
      div12Tick    <= hits(sysCnt_reg, `TCS_DIV12);
      div4Tick     <= hits(sysCnt_reg, `TCS_DIV4);
      div48Tick    <= hits(sysCnt_reg, `TCS_DIV48);
      extPrev_reg  <= extOscIn;
      slowPrev_reg <= slowOscIn;
      cmpPrev_reg  <= cmp0In;
      if (extRise)
        extCnt_reg <= extCnt_reg + 3'd1;
      if (slowRise)
        slowCnt_reg <= slowCnt_reg + 3'd1;
      extDiv8Tick  <= extRise && (extCnt_reg == `TCS_DIV8);
      slowTick     <= slowRise;
      slowDiv8Tick <= slowRise && (slowCnt_reg == `TCS_DIV8);
      cmpTick      <= cmp0In & ~cmpPrev_reg;
    end
  end

endmodule // tcs_prescaler

// *** core/tcs_timer_ctrl.v ***
`timescale 1ns/1ps
`include "tcs_defines.vh"

module tcs_timer_ctrl
(
  // clock, reset, enable
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       clkEn,
  // special-function byte access
  input  wire [7:0] sfrPage,
  input  wire [7:0] sfrAddr,
  input  wire       sfrWrEn,
  input  wire [7:0] sfrWrData,
  input  wire       sfrRdEn,
  output reg  [7:0] sfrRdData,
  // bit-addressable access
  input  wire [7:0] bitAddr,
  input  wire       bitWrEn,
  input  wire       bitWrData,
  input  wire       bitRdEn,
  output reg        bitRdData,
  // vector acknowledge pulses from the core
  input  wire       vecAckTmr0,
  input  wire       vecAckTmr1,
  input  wire       vecAckExt0,
  input  wire       vecAckExt1,
  // timer events and modes
  input  wire       tmr0Overflow,
  input  wire       tmr1Overflow,
  input  wire       tmr0CounterMode,
  input  wire       tmr1CounterMode,
  input  wire       tmr0PinIn,
  input  wire       tmr1PinIn,
  input  wire       tmr2Split,
  input  wire       tmr3Split,
  input  wire [1:0] tmr2ExtClkSelect,
  input  wire [1:0] tmr3ExtClkSelect,
  // external interrupts
  input  wire       extIrq0Input,
  input  wire       extIrq1Input,
  input  wire       extIrq0Polarity,
  input  wire       extIrq1Polarity,
  // clock sources
  input  wire       extOscIn,
  input  wire       slowOscIn,
  input  wire       cmp0In,
  // count enables
  output reg        tmr0Tick,
  output reg        tmr1Tick,
  output reg        tmr2LowTick,
  output reg        tmr2HighTick,
  output reg        tmr3LowTick,
  output reg        tmr3HighTick,
  // state
  output reg        tmr0Run,
  output reg        tmr1Run,
  output reg        tmr0OverflowFlag,
  output reg        tmr1OverflowFlag,
  output reg        extIrq0Flag,
  output reg        extIrq1Flag
);

  reg  [7:0] clkSel_reg;
  reg  [7:0] timer01_run_and_ext_irq_control_reg;
  reg  [7:0] timer01_run_and_ext_irq_control_next;
  reg  [7:0] tconWrVal;
  reg        ext0Prev_reg;
  reg        ext1Prev_reg;
  reg        pin0Prev_reg;
  reg        pin1Prev_reg;

  wire       div12Tick;
  wire       div4Tick;
  wire       div48Tick;
  wire       extDiv8Tick;
  wire       slowTick;
  wire       slowDiv8Tick;
  wire       cmpTick;

  // byte address match on the one decoded page
  function sfrHit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] target;
    begin
      sfrHit = (page == `TCS_PAGE) && (addr == target);
    end
  endfunction

  wire       tconSel   = sfrHit(sfrPage, sfrAddr, `TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_ADDR);
  wire       clkSelSel = sfrHit(sfrPage, sfrAddr, `TCS_CKSEL_ADDR);
  wire       bitHit    = (bitAddr[7:3] == `TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_BITBASE);
  wire       tconWr    = sfrWrEn && tconSel;
  wire       clkSelWr  = sfrWrEn && clkSelSel;
  wire       tconBitWr = bitWrEn && bitHit;

  // level that counts as active for a given polarity
  function activeLevel;
    input pin;
    input polarity;
    begin
      activeLevel = polarity ? pin : ~pin;
    end
  endfunction

  // external clock choice for timers 2 and 3
  function pickXclk;
    input [1:0] xsel;
    input       src00;
    input       src01;
    input       src11;
    begin
      case (xsel)
        2'b00:   pickXclk = src00;
        2'b01:   pickXclk = src01;
        2'b11:   pickXclk = src11;
        default: pickXclk = 1'b0;
      endcase
    end
  endfunction

  // flag update: write or ack may clear, hardware set wins
  function flagNext;
    input wrVal;
    input ackClear;
    input setEvt;
    begin
      flagNext = (wrVal & ~ackClear) | setEvt;
    end
  endfunction

  // byte clock: system clock or the external choice
  function byteClock;
    input sysSel;
    input xclk;
    begin
      byteClock = sysSel | xclk;
    end
  endfunction

  // timer 0/1 source: pin edges in counter mode, else clock choice
  function timerSource;
    input counterMode;
    input pinFall;
    input sysSel;
    input prescale;
    begin
      timerSource = counterMode ? pinFall : (sysSel | prescale);
    end
  endfunction

  // shared timer 0/1 prescaler choice
  function pickPrescale;
    input [1:0] field;
    input       tick12;
    input       tick4;
    input       tick48;
    input       tickExt8;
    begin
      case (field)
        2'b00:   pickPrescale = tick12;
        2'b01:   pickPrescale = tick4;
        2'b10:   pickPrescale = tick48;
        default: pickPrescale = tickExt8;
      endcase
    end
  endfunction

  // byte read multiplexer, unmapped reads as zero
  function [7:0] readByte;
    input       tconHit;
    input       clkSelHit;
    input [7:0] tconVal;
    input [7:0] clkSelVal;
    begin
      if (tconHit)
        readByte = tconVal;
      else if (clkSelHit)
        readByte = clkSelVal;
      else
        readByte = `TCS_UNMAPPED_READ;
    end
  endfunction

  tcs_prescaler u_prescaler
  (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .clkEn        (clkEn),
    .extOscIn     (extOscIn),
    .slowOscIn    (slowOscIn),
    .cmp0In       (cmp0In),
    .div12Tick    (div12Tick),
    .div4Tick     (div4Tick),
    .div48Tick    (div48Tick),
    .extDiv8Tick  (extDiv8Tick),
    .slowTick     (slowTick),
    .slowDiv8Tick (slowDiv8Tick),
    .cmpTick      (cmpTick)
  );

  // shared timer 0/1 prescaler output
  wire [1:0] prescaleField = clkSel_reg[`TCS_CK_PS_HI:`TCS_CK_PS_LO];
  wire       prescaleTick  = pickPrescale(prescaleField, div12Tick, div4Tick,
                                          div48Tick, extDiv8Tick);

  // external interrupt detection
  wire       ext0Active = activeLevel(extIrq0Input, extIrq0Polarity);
  wire       ext1Active = activeLevel(extIrq1Input, extIrq1Polarity);
  wire       ext0Edge   = timer01_run_and_ext_irq_control_reg[`TCS_TC_IT0];
  wire       ext1Edge   = timer01_run_and_ext_irq_control_reg[`TCS_TC_IT1];
  wire       ext0Set    = ext0Edge ? (ext0Active & ~ext0Prev_reg)
                          : ext0Active;
  wire       ext1Set    = ext1Edge ? (ext1Active & ~ext1Prev_reg)
                          : ext1Active;

  // counter-mode pin falling edges
  wire       pin0Fall   = pin0Prev_reg & ~tmr0PinIn;
  wire       pin1Fall   = pin1Prev_reg & ~tmr1PinIn;

  // vector acknowledge clears ext flags only in edge mode
  wire       ext0AckClr = vecAckExt0 & ext0Edge;
  wire       ext1AckClr = vecAckExt1 & ext1Edge;

  // timer control next value
  always @*
  begin
    tconWrVal = timer01_run_and_ext_irq_control_reg;
    if (tconWr)
      tconWrVal = sfrWrData;
    if (tconBitWr)
      tconWrVal[bitAddr[2:0]] = bitWrData;
    timer01_run_and_ext_irq_control_next = tconWrVal;
    timer01_run_and_ext_irq_control_next[`TCS_TC_TF1] = flagNext(tconWrVal[`TCS_TC_TF1],
                                      vecAckTmr1, tmr1Overflow);
    timer01_run_and_ext_irq_control_next[`TCS_TC_TF0] = flagNext(tconWrVal[`TCS_TC_TF0],
                                      vecAckTmr0, tmr0Overflow);
    // hardware set wins over a clear in the same cycle
    timer01_run_and_ext_irq_control_next[`TCS_TC_IE1] = flagNext(tconWrVal[`TCS_TC_IE1],
                                      ext1AckClr, ext1Set);
    timer01_run_and_ext_irq_control_next[`TCS_TC_IE0] = flagNext(tconWrVal[`TCS_TC_IE0],
                                      ext0AckClr, ext0Set);
  end

  // tick selection
  wire       tmr3_ext_clk_select = pickXclk(tmr3ExtClkSelect, div12Tick,
                               slowTick, extDiv8Tick);
  wire       tmr2_ext_clk_select = pickXclk(tmr2ExtClkSelect, div12Tick,
                               slowDiv8Tick, cmpTick);
  wire       t3Low  = byteClock(clkSel_reg[`TCS_CK_T3L], tmr3_ext_clk_select);
  wire       t2Low  = byteClock(clkSel_reg[`TCS_CK_T2L], tmr2_ext_clk_select);
  // high bytes follow the low byte outside split mode
  wire       t3High = tmr3Split ? byteClock(clkSel_reg[`TCS_CK_T3H], tmr3_ext_clk_select)
                      : t3Low;
  wire       t2High = tmr2Split ? byteClock(clkSel_reg[`TCS_CK_T2H], tmr2_ext_clk_select)
                      : t2Low;
  // select bit ignored while counting pin edges
  wire       t1Src  = timerSource(tmr1CounterMode, pin1Fall,
                      clkSel_reg[`TCS_CK_T1], prescaleTick);
  wire       t0Src  = timerSource(tmr0CounterMode, pin0Fall,
                      clkSel_reg[`TCS_CK_T0], prescaleTick);

  // state registers
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      clkSel_reg   <= `TCS_CKSEL_RESET;
      timer01_run_and_ext_irq_control_reg     <= `TCS_TIMER01_RUN_AND_EXT_IRQ_CONTROL_RESET;
      ext0Prev_reg <= 1'b1;
      ext1Prev_reg <= 1'b1;
      pin0Prev_reg <= 1'b0;
      pin1Prev_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      if (clkSelWr)
        clkSel_reg <= sfrWrData;
      timer01_run_and_ext_irq_control_reg     <= timer01_run_and_ext_irq_control_next;
      ext0Prev_reg <= ext0Active;
      ext1Prev_reg <= ext1Active;
      pin0Prev_reg <= tmr0PinIn;
      pin1Prev_reg <= tmr1PinIn;
    end
  end

  // registered outputs
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tmr0Tick         <= 1'b0;
      tmr1Tick         <= 1'b0;
      tmr2LowTick      <= 1'b0;
      tmr2HighTick     <= 1'b0;
      tmr3LowTick      <= 1'b0;
      tmr3HighTick     <= 1'b0;
      tmr0Run          <= 1'b0;
      tmr1Run          <= 1'b0;
      tmr0OverflowFlag <= 1'b0;
      tmr1OverflowFlag <= 1'b0;
      extIrq0Flag      <= 1'b0;
      extIrq1Flag      <= 1'b0;
    end
    else if (clkEn)
    begin
      tmr0Tick         <= t0Src & timer01_run_and_ext_irq_control_next[`TCS_TC_TR0];
      tmr1Tick         <= t1Src & timer01_run_and_ext_irq_control_next[`TCS_TC_TR1];
      tmr2LowTick      <= t2Low;
      tmr2HighTick     <= t2High;
      tmr3LowTick      <= t3Low;
      tmr3HighTick     <= t3High;
      tmr0Run          <= timer01_run_and_ext_irq_control_next[`TCS_TC_TR0];
      tmr1Run          <= timer01_run_and_ext_irq_control_next[`TCS_TC_TR1];
      tmr0OverflowFlag <= timer01_run_and_ext_irq_control_next[`TCS_TC_TF0];
      tmr1OverflowFlag <= timer01_run_and_ext_irq_control_next[`TCS_TC_TF1];
      extIrq0Flag      <= timer01_run_and_ext_irq_control_next[`TCS_TC_IE0];
      extIrq1Flag      <= timer01_run_and_ext_irq_control_next[`TCS_TC_IE1];
    end
  end

  // read port, one cycle after the strobe
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sfrRdData <= `TCS_UNMAPPED_READ;
      bitRdData <= 1'b0;
    end
    else if (clkEn)
    begin
      // read data holds until the next read strobe
      if (sfrRdEn)
        sfrRdData <= readByte(tconSel, clkSelSel, timer01_run_and_ext_irq_control_reg, clkSel_reg);
      if (bitRdEn)
        bitRdData <= bitHit & timer01_run_and_ext_irq_control_reg[bitAddr[2:0]];
    end
  end

endmodule // tcs_timer_ctrl

// *** verif/tcs_timer_ctrl_sva.sv ***
`timescale 1ns/1ps

module tcs_timer_ctrl_sva
(
  // clock and reset
  input wire       core_clk,
  input wire       rst_b,
  input wire       clkEn,
  // byte access
  input wire [7:0] sfrPage,
  input wire [7:0] sfrAddr,
  input wire       sfrWrEn,
  input wire [7:0] sfrWrData,
  input wire       sfrRdEn,
  input wire [7:0] sfrRdData,
  input wire       bitWrEn,
  // events
  input wire       vecAckTmr1,
  input wire       tmr0Overflow,
  input wire       tmr1Overflow,
  // state
  input wire       tmr0Tick,
  input wire       tmr1Tick,
  input wire       tmr0Run,
  input wire       tmr1Run,
  input wire       tmr0OverflowFlag,
  input wire       tmr1OverflowFlag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_ovf1_set: assert property (clkEn && tmr1Overflow |=> tmr1OverflowFlag)
    else $error("timer 1 flag not set");
  a_ovf0_set: assert property (clkEn && tmr0Overflow |=> tmr0OverflowFlag)
    else $error("timer 0 flag not set");
  a_ack1_clear: assert property (
    clkEn && vecAckTmr1 && !tmr1Overflow && !sfrWrEn && !bitWrEn
    |=> !tmr1OverflowFlag) else $error("ack left timer 1 flag");
  a_flag1_hold: assert property (
    tmr1OverflowFlag && !vecAckTmr1 && !sfrWrEn && !bitWrEn
    |=> tmr1OverflowFlag) else $error("timer 1 flag dropped");
  a_tick1_run: assert property (tmr1Tick |-> tmr1Run)
    else $error("timer 1 ticks while stopped");
  a_tick0_run: assert property (tmr0Tick |-> tmr0Run)
    else $error("timer 0 ticks while stopped");
  a_run_write: assert property (
    clkEn && sfrWrEn && sfrPage == 8'h00 && sfrAddr == 8'h88 && !bitWrEn
    |=> tmr1Run == $past(sfrWrData[6]) && tmr0Run == $past(sfrWrData[4]))
    else $error("run bits not written");
  a_rd_unmapped: assert property (
    clkEn && sfrRdEn && sfrAddr != 8'h88 && sfrAddr != 8'h8E
    |=> sfrRdData == 8'h00) else $error("unmapped read not zero");
endmodule // tcs_timer_ctrl_sva

bind tcs_timer_ctrl tcs_timer_ctrl_sva sva (.*);

// *** verif/tcs_cpu_model.sv ***
`timescale 1ns/1ps

module tcs_cpu_model
(
  // clock and service requests
  input wire       core_clk,
  input wire [3:0] ackReq,
  // vector acknowledge pulses
  output reg       vecAckTmr0,
  output reg       vecAckTmr1,
  output reg       vecAckExt0,
  output reg       vecAckExt1
);
  // one pulse per serviced source
  always @(posedge core_clk)
    {vecAckExt1, vecAckExt0, vecAckTmr1, vecAckTmr0} <= ackReq;
endmodule // tcs_cpu_model

// *** verif/tb_timer_clock_select_and_run_control.sv ***
`timescale 1ns/1ps

module tb_timer_clock_select_and_run_control;
  reg        core_clk, rst_b, clkEn, sfrWrEn, sfrRdEn, bitWrEn, bitWrData;
  reg        bitRdEn, tmr0Overflow, tmr1Overflow, tmr0CounterMode;
  reg        tmr1CounterMode, tmr0PinIn, tmr1PinIn, tmr2Split, tmr3Split;
  reg        extIrq0Input, extIrq1Input, extIrq0Polarity, extIrq1Polarity;
  reg        extOscIn, slowOscIn, cmp0In, cnt;
  reg  [7:0] sfrPage, sfrAddr, sfrWrData, bitAddr, cks;
  reg  [1:0] tmr2ExtClkSelect, tmr3ExtClkSelect;
  reg  [3:0] ackReq;
  reg [31:0] rnd;
  reg  [8:0] cnts [0:5];
  reg  [8:0] want;
  integer    badCount, comparisons, j, k, m;
  wire [7:0] sfrRdData;
  wire       bitRdData, vecAckTmr0, vecAckTmr1, vecAckExt0, vecAckExt1;
  wire       tmr0Tick, tmr1Tick, tmr2LowTick, tmr2HighTick, tmr3LowTick;
  wire       tmr3HighTick, tmr0Run, tmr1Run, tmr0OverflowFlag;
  wire       tmr1OverflowFlag, extIrq0Flag, extIrq1Flag;
  wire [5:0] tk = {tmr3HighTick, tmr3LowTick, tmr2HighTick, tmr2LowTick,
                   tmr1Tick, tmr0Tick};

  tcs_timer_ctrl dut (.*);
  tcs_cpu_model cpu (.*);

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ticks in 192 cycles for a selection
  function [8:0] expTicks(input s, input [1:0] p, input run);
    expTicks = !run ? 9'h000 : s ? 9'h0C0 : p == 2'h0 ? 9'h010 :
      p == 2'h1 ? 9'h030 : p == 2'h2 ? 9'h004 : 9'h00C;
  endfunction
  // ticks in 192 cycles for an external choice (slow sources unused)
  function [8:0] expX(input t3, input [1:0] x);
    expX = x == 2'h0 ? 9'h010 : x == 2'h2 ? 9'h000 :
      (t3 && x == 2'h3) ? 9'h00C : 9'h1FF;
  endfunction

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    rnd <= lfsr(rnd);
    extOscIn <= rst_b & ~extOscIn;
    {slowOscIn, cmp0In, tmr0PinIn, tmr1PinIn} <= rnd[3:0];
    for (m = 0; m < 6; m = m + 1)
      cnts[m] <= cnt ? cnts[m] + tk[m] : 9'h000;
  end

  task chk(input [8:0] seen, input [8:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      badCount = badCount + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // op: 0 byte write, 1 byte read, 2 bit write, 3 bit read
  task xfer(input [1:0] op, input [7:0] p, input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    {sfrPage, sfrAddr, bitAddr, sfrWrData, bitWrData} <= {p, a, a, d, d[0]};
    {bitRdEn, bitWrEn, sfrRdEn, sfrWrEn} <= 4'h1 << op;
    @(posedge core_clk);
    {bitRdEn, bitWrEn, sfrRdEn, sfrWrEn} <= 4'h0;
    #1;
    if (op[0])
      chk(op[1] ? {8'h00, bitRdData} : {1'b0, sfrRdData}, {1'b0, d});
  endtask

  task ack(input [1:0] i);
    @(posedge core_clk);
    ackReq <= 4'h1 << i;
    @(posedge core_clk);
    ackReq <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask

  task pinWait;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task reportAndStop;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (8000) @(posedge core_clk);
    badCount = badCount + 1;
    reportAndStop;
  end

  initial
  begin
    {rst_b, sfrWrEn, sfrRdEn, bitWrEn, bitWrData, bitRdEn, cnt} = 7'h00;
    {tmr0Overflow, tmr1Overflow, tmr0CounterMode, tmr1CounterMode} = 4'h0;
    {extIrq1Input, extIrq0Polarity} = 2'h0;
    {clkEn, tmr2Split, tmr3Split, extIrq0Input, extIrq1Polarity} = 5'h1F;
    ackReq = 4'h0;
    {sfrPage, sfrAddr, sfrWrData, bitAddr} = 32'h0;
    {tmr2ExtClkSelect, tmr3ExtClkSelect} = 4'h0;
    badCount = 0;
    comparisons = 0;
    rnd = 32'hFB84B8DA;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    xfer(2'h1, 8'h00, 8'h88, 8'h00);
    xfer(2'h1, 8'h00, 8'h8E, 8'h00);
    for (k = 0; k < 4; k = k + 1)
    begin
      cks = rnd[7:0];
      xfer(2'h0, 8'h00, 8'h8E, cks);
      xfer(2'h1, 8'h00, 8'h8E, cks);
    end
    xfer(2'h0, 8'h01, 8'h8E, ~cks);
    xfer(2'h1, 8'h00, 8'h8E, cks);
    xfer(2'h1, 8'h00, 8'h89, 8'h00);
    xfer(2'h3, 8'h00, 8'h90, 8'h00);
    xfer(2'h0, 8'h00, 8'h88, 8'h50);
    xfer(2'h3, 8'h00, 8'h8E, 8'h01);
    for (k = 0; k < 6; k = k + 1)
    begin
      cks = (k[0] ? 8'hA8 : 8'h54) | k[1:0];
      if (k == 4)
        xfer(2'h0, 8'h00, 8'h88, 8'h00);
      if (k == 5)
        {tmr2Split, tmr3Split, tmr2ExtClkSelect, tmr3ExtClkSelect} <= 6'h0B;
      xfer(2'h0, 8'h00, 8'h8E, cks);
      repeat (60) @(posedge core_clk);
      cnt <= 1'b1;
      repeat (192) @(posedge core_clk);
      cnt <= 1'b0;
      #1;
      for (j = 0; j < 6; j = j + 1)
      begin
        if (j > 1)
          want = cks[j + 2 - (k == 5 && j[0])] ? 9'h0C0 :
            expX(j > 3, j > 3 ? tmr3ExtClkSelect : tmr2ExtClkSelect);
        else
          want = expTicks(cks[j + 2], cks[1:0], k < 4);
        chk(cnts[j], want);
      end
    end
    @(posedge core_clk) {clkEn, tmr1Overflow} <= 2'h1;
    @(posedge core_clk) tmr1Overflow <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(tmr1OverflowFlag, 1'b0);
    clkEn <= 1'b1;
    @(posedge core_clk) tmr1Overflow <= 1'b1;
    @(posedge core_clk) tmr1Overflow <= 1'b0;
    #1 chk(tmr1OverflowFlag, 1'b1);
    ack(2'h1);
    chk(tmr1OverflowFlag, 1'b0);
    @(posedge core_clk) tmr0Overflow <= 1'b1;
    @(posedge core_clk) tmr0Overflow <= 1'b0;
    xfer(2'h1, 8'h00, 8'h88, 8'h20);
    xfer(2'h2, 8'h00, 8'h8D, 8'h00);
    chk(tmr0OverflowFlag, 1'b0);
    xfer(2'h2, 8'h00, 8'h8A, 8'h01);
    @(posedge core_clk) extIrq1Input <= 1'b1;
    pinWait;
    chk(extIrq1Flag, 1'b1);
    ack(2'h3);
    chk(extIrq1Flag, 1'b0);
    @(posedge core_clk) extIrq0Input <= 1'b0;
    pinWait;
    chk(extIrq0Flag, 1'b1);
    ack(2'h2);
    chk(extIrq0Flag, 1'b1);
    @(posedge core_clk) extIrq0Input <= 1'b1;
    pinWait;
    xfer(2'h2, 8'h00, 8'h89, 8'h00);
    chk(extIrq0Flag, 1'b0);
    xfer(2'h2, 8'h00, 8'h88, 8'h01);
    @(posedge core_clk) extIrq0Input <= 1'b0;
    pinWait;
    chk(extIrq0Flag, 1'b1);
    ack(2'h2);
    chk(extIrq0Flag, 1'b0);
    reportAndStop;
  end
endmodule // tb_timer_clock_select_and_run_control
